// file: rtl/pdsw_device.sv
// Device end of the divider serial write port: shifter and divider registers.
// Assumes link pins are asynchronous to I_CLK_SYS and sampled well above their rate.
//
// Operation
// - three host wires, no readback path
// - frame is 25 bits while strobe low
// - bits 15..0 are the data word
// - bits 20..16 select the register
// - bits 24..21 must match device code
// - data sampled on rising serial clock
// - host lowers strobe first, raises it last
// - host clock respects minimum period, high
// - three writable divider configuration registers
// - reference register holds 11-bit ratio
// - high feedback bits 1..0 are MSBs
// - low feedback bits 15..0 are LSBs
// - reference bits 15..11 are other settings
// - high feedback bits 15..2 other settings
// - LO output buffer always enabled
// - reference ratio legal 1 to 2047
// - feedback value legal 1024 to 262143
`timescale 1ns/10ps
`include "pdsw_params.svh"
module pdsw_device
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_CE,
   pdsw_link_if.device link,
   output logic [`PDSW_REF_RATIO_BITS-1:0] O_REF_RATIO,
   output logic [4:0] O_REF_CONFIG,
   output logic [17:0] O_FB_VALUE,
   output logic [13:0] O_FB_CONFIG,
   output logic O_REF_RATIO_VALID,
   output logic O_FB_VALUE_VALID,
   output logic O_LO_OUT_ENABLE,
   output logic O_WRITE_DONE,
   output logic O_FRAME_ERROR
);
   import pdsw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Layout checks: the shifter and the counter assume the fields tile the frame
   if ((`PDSW_DEVA_MSB != `PDSW_FRAME_BITS - 1) || (`PDSW_DEVA_LSB != `PDSW_REGA_MSB + 1))
   begin : g_bad_dev_field
      $error("device address field does not close the frame");
   end
   if ((`PDSW_REGA_LSB != `PDSW_DATA_MSB + 1) || (`PDSW_REF_RATIO_BITS > `PDSW_DATA_MSB + 1))
   begin : g_bad_data_field
      $error("register address or ratio field misplaced");
   end
   // The bit counter saturates at 63, so a frame must stay below that, at 62 bits at most
   if (`PDSW_FRAME_BITS > 62)
   begin : g_bad_frame_len
      $error("frame too long for the bit counter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers: three link wires, two flops each
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
   logic sck_s, stb_s, dat_s, sck_rise, stb_rise, stb_fall;

   // Only the second stage and its one-cycle-delayed copy feed logic
   always_comb
   begin
      sync1_d = {link.sck, link.strobe_n, link.sdata};
      sync2_d = sync1_q;
      prev_d = sync2_q;
      sck_s = sync2_q[2];
      stb_s = sync2_q[1];
      dat_s = sync2_q[0];
      sck_rise = sck_s & ~prev_q[2];
      stb_rise = stb_s & ~prev_q[1];
      stb_fall = ~stb_s & prev_q[1];
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         sync1_q <= 3'h2;
         sync2_q <= 3'h2;
         prev_q <= 3'h2;
      end
      else if (I_CE)
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shifter and divider registers
   pdsw_frame_t shift_q, shift_d;
   logic [5:0] count_q, count_d;
   pdsw_word_t ref_q, ref_d, fblo_q, fblo_d, fbhi_q, fbhi_d;
   logic done_q, done_d, err_q, err_d;
   logic match, complete;

   always_comb
   begin
      shift_d = shift_q;
      count_d = count_q;
      ref_d = ref_q;
      fblo_d = fblo_q;
      fbhi_d = fbhi_q;
      done_d = 1'b0;
      err_d = 1'b0;
      // Device code compare and exact bit count; a short or long frame is dropped
      match = (shift_q[`PDSW_DEVA_MSB:`PDSW_DEVA_LSB] == `PDSW_DEV_CODE);
      complete = (count_q == 6'(`PDSW_FRAME_BITS));
      if (stb_fall)
      begin
         count_d = 6'h00;
      end
      else if (!stb_s && sck_rise)
      begin
         // Most significant bit arrives first and ends at bit 24
         shift_d = {shift_q[`PDSW_FRAME_BITS-2:0], dat_s};
         if (count_q != 6'h3F)
         begin
            count_d = count_q + 6'h01;
         end
      end
      if (stb_rise)
      begin
         if (complete && match)
         begin
            done_d = 1'b1;
            // Register select from the address field, data from bits 15..0
            case (shift_q[`PDSW_REGA_MSB:`PDSW_REGA_LSB])
               `PDSW_ADDR_REF: ref_d = shift_q[`PDSW_DATA_MSB:0];
               `PDSW_ADDR_FBLO: fblo_d = shift_q[`PDSW_DATA_MSB:0];
               `PDSW_ADDR_FBHI: fbhi_d = shift_q[`PDSW_DATA_MSB:0];
               default: done_d = 1'b0;
            endcase
         end
         else
         begin
            err_d = 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         shift_q <= '0;
         count_q <= 6'h00;
         ref_q <= `PDSW_REF_RESET;
         fblo_q <= `PDSW_FBLO_RESET;
         fbhi_q <= `PDSW_FBHI_RESET;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end
      else if (I_CE)
      begin
         shift_q <= shift_d;
         count_q <= count_d;
         ref_q <= ref_d;
         fblo_q <= fblo_d;
         fbhi_q <= fbhi_d;
         done_q <= done_d;
         err_q <= err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output fields, registered so every output comes from a flop
   logic [17:0] fb_val_q, fb_val_d;
   logic ref_ok_q, ref_ok_d, fb_ok_q, fb_ok_d, lo_en_q;

   // Legality flags: the core keeps running on illegal values, the flag warns
   always_comb
   begin
      fb_val_d = {fbhi_d[`PDSW_FB_HI_BITS-1:0], fblo_d};
      ref_ok_d = (ref_d[`PDSW_REF_RATIO_BITS-1:0] >= `PDSW_REF_RATIO_MIN);
      fb_ok_d = (fb_val_d >= `PDSW_FB_MIN) && (fb_val_d <= `PDSW_FB_MAX);
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         fb_val_q <= 18'h0_0400;
         ref_ok_q <= 1'b1;
         fb_ok_q <= 1'b1;
         lo_en_q <= 1'b1;
      end
      else if (I_CE)
      begin
         fb_val_q <= fb_val_d;
         ref_ok_q <= ref_ok_d;
         fb_ok_q <= fb_ok_d;
         lo_en_q <= 1'b1;
      end
   end

   // Reference ratio and its separate settings field
   assign O_REF_RATIO = ref_q[`PDSW_REF_RATIO_BITS-1:0];
   assign O_REF_CONFIG = ref_q[15:11];
   assign O_FB_VALUE = fb_val_q;
   assign O_FB_CONFIG = fbhi_q[15:2];
   assign O_REF_RATIO_VALID = ref_ok_q;
   assign O_FB_VALUE_VALID = fb_ok_q;
   assign O_LO_OUT_ENABLE = lo_en_q;
   assign O_WRITE_DONE = done_q;
   assign O_FRAME_ERROR = err_q;
endmodule // pdsw_device

// file: rtl/pdsw_params.svh
// Constants for the divider serial write port: frame layout, addresses, timing.
// Assumes inclusion by both link ends and by the package.
`ifndef PDSW_PARAMS_SVH
`define PDSW_PARAMS_SVH

`define PDSW_FRAME_BITS 25
`define PDSW_DATA_MSB 15
`define PDSW_REGA_LSB 16
`define PDSW_REGA_MSB 20
`define PDSW_DEVA_LSB 21
`define PDSW_DEVA_MSB 24
// Device code is arbitrary, chosen for this design
`define PDSW_DEV_CODE 4'h9
// Register addresses inside the 5-bit address field
`define PDSW_ADDR_REF 5'h0_0
`define PDSW_ADDR_FBLO 5'h0_1
`define PDSW_ADDR_FBHI 5'h0_2
`define PDSW_REF_RATIO_BITS 11
`define PDSW_FB_HI_BITS 2
`define PDSW_REF_RATIO_MIN 11'h001
`define PDSW_FB_MIN 18'h0_0400
`define PDSW_FB_MAX 18'h3_FFFF
// Reset values of the stored words
`define PDSW_REF_RESET 16'h0001
`define PDSW_FBLO_RESET 16'h0400
`define PDSW_FBHI_RESET 16'h0000
// Host timing in ns and the system clock period in ns
`define PDSW_SYS_PERIOD_NS 100
`define PDSW_SCK_PERIOD_MIN_NS 25
`define PDSW_SCK_HIGH_MIN_NS 10
`define PDSW_STROBE_HIGH_MIN_NS 10
`define PDSW_STROBE_HIGH_CYC ((`PDSW_STROBE_HIGH_MIN_NS + `PDSW_SYS_PERIOD_NS - 1) / `PDSW_SYS_PERIOD_NS)
`define PDSW_SCK_DIV_DEFAULT 4

`endif

// file: rtl/pdsw_pkg.sv
// Types shared by both ends of the divider serial write port.
// Assumes the constant header is on the include path.
`include "pdsw_params.svh"
package pdsw_pkg;
   typedef logic [`PDSW_FRAME_BITS-1:0] pdsw_frame_t;
   typedef logic [15:0] pdsw_word_t;
   typedef logic [4:0] pdsw_reg_addr_t;
   typedef logic [3:0] pdsw_dev_addr_t;
   typedef enum logic [1:0]
   {
      PDSW_IDLE = 2'b00,
      PDSW_SHIFT = 2'b01,
      PDSW_CLOSE = 2'b10
   } pdsw_host_state_t;
endpackage : pdsw_pkg

// file: rtl/pdsw_link_if.sv
// Three-wire write link between host and synthesizer.
// Assumes both ends share one system clock; the link clock is a plain wire.
`timescale 1ns/10ps
interface pdsw_link_if;
   logic sck;
   logic strobe_n;
   logic sdata;
   modport host (output sck, output strobe_n, output sdata);
   modport device (input sck, input strobe_n, input sdata);
endinterface : pdsw_link_if

// file: rtl/pdsw_host.sv
// Host end: shifts one 25-bit frame per request onto the three-wire link.
// Assumes the device samples with its own clock; serial clock made by a divider.
`timescale 1ns/10ps
`include "pdsw_params.svh"
module pdsw_host
#(
   parameter int SCK_HALF = `PDSW_SCK_DIV_DEFAULT
)
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_CE,
   input wire logic I_REQ,
   input wire pdsw_pkg::pdsw_reg_addr_t I_REG_ADDR,
   input wire pdsw_pkg::pdsw_word_t I_DATA,
   output logic O_BUSY,
   output logic O_DONE,
   pdsw_link_if.host link
);
   import pdsw_pkg::*;

   // Device samples through two flops, so each half period needs several cycles
   if (SCK_HALF < 3 || SCK_HALF > 255)
   begin : g_bad_half
      $error("SCK_HALF out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   pdsw_host_state_t st_q, st_d;
   pdsw_frame_t frame_q, frame_d;
   logic [4:0] bits_q, bits_d;
   logic [7:0] div_q, div_d;
   logic sck_q, sck_d, stb_q, stb_d, dat_q, dat_d, done_q, done_d;
   logic busy_q, busy_d;

   always_comb
   begin
      st_d = st_q;
      frame_d = frame_q;
      bits_d = bits_q;
      div_d = div_q;
      sck_d = sck_q;
      stb_d = stb_q;
      dat_d = dat_q;
      done_d = 1'b0;
      case (st_q)
         PDSW_IDLE:
         begin
            if (I_REQ)
            begin
               // Device code first, then address, then data
               frame_d = {`PDSW_DEV_CODE, I_REG_ADDR, I_DATA};
               stb_d = 1'b0;
               dat_d = frame_d[`PDSW_FRAME_BITS-1];
               bits_d = 5'(`PDSW_FRAME_BITS);
               div_d = 8'h00;
               st_d = PDSW_SHIFT;
            end
         end
         PDSW_SHIFT:
         begin
            // Data set while clock low, stable across the rise
            div_d = div_q + 8'h01;
            if (div_q == 8'(SCK_HALF - 1))
            begin
               div_d = 8'h00;
               if (!sck_q)
               begin
                  sck_d = 1'b1;
               end
               else
               begin
                  sck_d = 1'b0;
                  frame_d = {frame_q[`PDSW_FRAME_BITS-2:0], 1'b0};
                  bits_d = bits_q - 5'h01;
                  if (bits_q == 5'h01)
                  begin
                     st_d = PDSW_CLOSE;
                  end
               end
            end
            dat_d = frame_d[`PDSW_FRAME_BITS-1];
         end
         PDSW_CLOSE:
         begin
            // Strobe rises only after the last fall, after one half period
            div_d = div_q + 8'h01;
            if (div_q == 8'(SCK_HALF - 1))
            begin
               stb_d = 1'b1;
               done_d = 1'b1;
               st_d = PDSW_IDLE;
            end
         end
         default: st_d = PDSW_IDLE;
      endcase
      // Busy follows the strobe but is registered on its own
      busy_d = ~stb_d;
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         st_q <= PDSW_IDLE;
         frame_q <= '0;
         bits_q <= 5'h00;
         div_q <= 8'h00;
         sck_q <= 1'b0;
         stb_q <= 1'b1;
         dat_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else if (I_CE)
      begin
         st_q <= st_d;
         frame_q <= frame_d;
         bits_q <= bits_d;
         div_q <= div_d;
         sck_q <= sck_d;
         stb_q <= stb_d;
         dat_q <= dat_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   // Only three host-driven wires
   assign link.sck = sck_q;
   assign link.strobe_n = stb_q;
   assign link.sdata = dat_q;
   assign O_BUSY = busy_q;
   assign O_DONE = done_q;
endmodule // pdsw_host

// file: testbench/pdsw_link_props.sv
// Checker of the three-wire write link between host and device ends.
// Assumes it sees the link pins and the shared system clock and reset.
`timescale 1ns/10ps
`include "pdsw_params.svh"
module pdsw_link_props
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_sck,
   input wire logic i_strobe_n,
   input wire logic i_sdata
);
   logic sck_q;
   logic stb_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [24:0] sh_q;
   logic [24:0] sh_d;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////
   // Count rising link clocks in a frame and keep the bits seen
   always_comb
   begin
      cnt_d = cnt_q;
      sh_d = sh_q;
      if (stb_q && !i_strobe_n)
      begin
         cnt_d = 6'h00;
      end
      else if (!i_strobe_n && i_sck && !sck_q)
      begin
         cnt_d = cnt_q + 6'h01;
         sh_d = {sh_q[23:0], i_sdata};
      end
   end
   // Registers only; frame count survives until the next strobe fall
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         sck_q <= 1'b0;
         stb_q <= 1'b1;
         cnt_q <= 6'h00;
         sh_q <= 25'h000_0000;
      end
      else
      begin
         sck_q <= i_sck;
         stb_q <= i_strobe_n;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Link rules
   idle_sck_low_a: assert property (i_strobe_n |-> !i_sck)
      else $error("link clock high outside frame");
   strobe_lead_a: assert property ($fell(i_strobe_n) |-> !i_sck [*4])
      else $error("clock rose too soon after strobe fall");
   strobe_trail_a: assert property ($rose(i_strobe_n) |-> !$past(i_sck) && !$past(i_sck, 3))
      else $error("strobe rose too soon after clock fall");
   sck_high_time_a: assert property ($rose(i_sck) |-> i_sck [*4] ##1 !i_sck)
      else $error("link clock high time wrong");
   sck_low_time_a: assert property ($fell(i_sck) |-> !i_sck [*4])
      else $error("link clock low time short");
   data_stable_a: assert property ($rose(i_sck) |-> $stable(i_sdata) ##1 $stable(i_sdata))
      else $error("data moved around clock rise");
   frame_length_a: assert property ($rose(i_strobe_n) |-> cnt_q == 6'h19)
      else $error("frame bit count wrong");
   dev_code_first_a: assert property ($rose(i_strobe_n) |-> sh_q[24:21] == `PDSW_DEV_CODE)
      else $error("device code not sent first");
endmodule // pdsw_link_props

// file: testbench/pdsw_device_tb.sv
// Bench joining host and device ends, plus a rogue driver on a second link.
// Assumes the design files and the constant header are compiled first.
`timescale 1ns/10ps
`include "pdsw_params.svh"
module pdsw_device_tb;
   import pdsw_pkg::*;
   logic clk_sys;
   logic reset;
   logic req;
   logic ce2;
   pdsw_reg_addr_t addr;
   pdsw_word_t data;
   logic busy, done, wr, err, wr2, err2, rv, fv, lo;
   logic [10:0] ratio, ratio2;
   logic [4:0] rcfg;
   logic [17:0] fbv;
   logic [13:0] fcfg;
   int n_errors = 0;
   int n_tests = 0;
   int n_wr = 0;
   int n_err = 0;
   int n_wr2 = 0;
   int n_err2 = 0;
   pdsw_link_if link();
   pdsw_link_if link_bad();
   pdsw_host i_pdsw_host (.I_CLK_SYS(clk_sys), .I_RESET(reset), .I_CE(1'b1), .I_REQ(req),
      .I_REG_ADDR(addr), .I_DATA(data), .O_BUSY(busy), .O_DONE(done), .link(link.host));
   pdsw_device i_pdsw_device (.I_CLK_SYS(clk_sys), .I_RESET(reset), .I_CE(1'b1), .link(link.device),
      .O_REF_RATIO(ratio), .O_REF_CONFIG(rcfg), .O_FB_VALUE(fbv), .O_FB_CONFIG(fcfg),
      .O_REF_RATIO_VALID(rv), .O_FB_VALUE_VALID(fv), .O_LO_OUT_ENABLE(lo), .O_WRITE_DONE(wr),
      .O_FRAME_ERROR(err));
   pdsw_device i_pdsw_device_2 (.I_CLK_SYS(clk_sys), .I_RESET(reset), .I_CE(ce2),
      .link(link_bad.device), .O_REF_RATIO(ratio2), .O_REF_CONFIG(), .O_FB_VALUE(), .O_FB_CONFIG(),
      .O_REF_RATIO_VALID(), .O_FB_VALUE_VALID(), .O_LO_OUT_ENABLE(), .O_WRITE_DONE(wr2),
      .O_FRAME_ERROR(err2));
   pdsw_link_props i_pdsw_link_props (.i_clk_sys(clk_sys), .i_reset(reset), .i_sck(link.sck),
      .i_strobe_n(link.strobe_n), .i_sdata(link.sdata));
   ////////////////////////////////////////////////////////////////////////
   // Clock, and pulse counters so no one-cycle pulse is missed
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      n_wr += (wr === 1'b1);
      n_err += (err === 1'b1);
      n_wr2 += (wr2 === 1'b1);
      n_err2 += (err2 === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One host frame; waits for done, then for the device to latch
   task automatic put(input logic [4:0] a, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      req <= 1'b1;
      addr <= a;
      data <= d;
      @(posedge clk_sys);
      req <= 1'b0;
      @(negedge clk_sys);
      check(busy, 1'b1);
      do
      begin
         @(posedge clk_sys);
         k++;
      end while (done !== 1'b1 && k < 300);
      check(k < 300, 1);
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      check(busy, 1'b0);
   endtask
   // Rogue host: n bits MSB first at an 800 ns link period
   task automatic rogue(input logic [31:0] f, input int n);
      @(posedge clk_sys);
      link_bad.strobe_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         link_bad.sdata <= f[i];
         repeat (4) @(posedge clk_sys);
         link_bad.sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         link_bad.sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      link_bad.strobe_n <= 1'b1;
      link_bad.sdata <= ~f[0];
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial
   begin
      reset = 1'b1;
      req = 1'b0;
      ce2 = 1'b1;
      addr = 5'h0_0;
      data = 16'h0000;
      link_bad.sck = 1'b0;
      link_bad.strobe_n = 1'b1;
      link_bad.sdata = 1'b0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      check({ratio, rv, fbv, fv, lo}, {11'h001, 1'b1, 18'h0_0400, 1'b1, 1'b1});
      put(5'h0_0, {5'h15, 11'h060});
      check({rcfg, ratio, rv}, {5'h15, 11'h060, 1'b1});
      put(5'h0_1, 16'h1194);
      put(5'h0_2, {14'h2AAA, 2'b00});
      check({fcfg, fbv}, {14'h2AAA, 18'h0_1194});
      put(5'h0_2, 16'h0003);
      put(5'h0_1, 16'hFFFF);
      check({fbv, fv}, {18'h3_FFFF, 1'b1});
      put(5'h0_2, 16'h0000);
      put(5'h0_1, 16'h03FF);
      check({fbv, fv}, {18'h0_03FF, 1'b0});
      put(5'h0_0, 16'h0000);
      check({ratio, rv}, {11'h000, 1'b0});
      put(5'h1_F, 16'h07FF);
      check({ratio, rcfg}, {11'h000, 5'h00});
      check(fbv, 18'h0_03FF);
      check(n_wr, 8);
      check(n_err, 0);
      rogue({7'h00, 4'h3, 5'h0_0, 16'h0123}, 25);
      check(ratio2, 11'h001);
      check(n_err2, 1);
      rogue({7'h00, `PDSW_DEV_CODE, 5'h0_0, 16'h0123}, 24);
      rogue({6'h00, `PDSW_DEV_CODE, 5'h0_0, 16'h0123, 1'b1}, 26);
      check(ratio2, 11'h001);
      check(n_err2, 3);
      check(n_wr2, 0);
      rogue({7'h00, `PDSW_DEV_CODE, 5'h0_0, 16'h0123}, 25);
      check(ratio2, 11'h123);
      check(n_wr2, 1);
      // Clock enable low: a whole good frame must leave the device untouched
      @(posedge clk_sys);
      ce2 <= 1'b0;
      rogue({7'h00, `PDSW_DEV_CODE, 5'h0_0, 16'h0456}, 25);
      @(posedge clk_sys);
      ce2 <= 1'b1;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      check(ratio2, 11'h123);
      check(n_wr2, 1);
      check(n_err2, 3);
      print_verdict();
   end
   // Watchdog well beyond the roughly 3000 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      print_verdict();
   end
endmodule // pdsw_device_tb
